// ### sed_defines.svh
// Opcode fields and phase timing constants for the subroutine exit decoder.
`ifndef SED_DEFINES_SVH
`define SED_DEFINES_SVH
`define SED_LIT_TOP      2'h3
`define SED_LIT_MID      2'h1
`define SED_PLAIN_OPCODE 14'h0008
`define SED_PHASES       2'h3
`define SED_LIT_MSB      7
`define SED_ACC_RESET    8'h00
`endif

// ### sed_exit_decode.sv
// Decode and execution sequencing for the two subroutine exit instructions.
`timescale 1ns/1ps
`include "sed_defines.svh"
// How it works
// - Literal exit writes its 8-bit literal to the accumulator in phase four.
// - Literal exit pops the stack into the program counter in phase four.
// - Literal exit lasts two cycles; second cycle idle, no status change.
// - Plain exit pops stack into program counter in phase four, accumulator untouched.
// - Plain exit lasts two cycles; its second cycle is idle.
module sed_exit_decode
  import sed_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       instr_valid_i,
  input  wire logic [13:0] instr_word_i,
  input  wire logic [12:0] stack_top_entry_i,
  output logic            stack_pop_o,
  output logic            pc_load_o,
  output logic [12:0]     pc_value_o,
  output logic            acc_write_o,
  output logic [7:0]      acc_data_o,
  output logic            fetch_flush_o,
  output logic            busy_o,
  output logic [1:0]      phase_o
);
  sed_instr_s instr;
  sed_cyc_e   cyc;
  sed_cyc_e   next_cyc;
  logic [1:0] phase;
  logic [1:0] next_phase;
  sed_ctrl_s  ctrl;
  sed_ctrl_s  next_ctrl;
  logic [12:0] next_pc_value;
  logic [13:0] held;
  logic [13:0] next_held;
  logic        is_lit;
  logic        is_plain;
  logic        last_phase;

  assign instr.valid = instr_valid_i;
  assign instr.word  = instr_word_i;
  assign last_phase  = (phase == `SED_PHASES);
  assign is_lit   = (held[13:12] == `SED_LIT_TOP) && (held[11:10] == `SED_LIT_MID);
  assign is_plain = (held == `SED_PLAIN_OPCODE);

  // Instructions are captured in phase one of an executing cycle; the held
  // word is what phase four acts on, so mid-cycle input changes are harmless.
  always_comb
  begin
    next_phase    = phase + 2'h1;
    next_cyc      = cyc;
    next_held     = held;
    next_ctrl     = '0;
    next_pc_value = pc_value_o;
    if (phase == 2'h0 && cyc == SED_EXEC)
    begin
      next_held = instr.valid ? instr.word : 14'h0000;
    end
    if (phase == 2'h2 && cyc == SED_EXEC && (is_lit || is_plain))
    begin
      next_ctrl.pop     = 1'b1;
      next_ctrl.pc_load = 1'b1;
      next_pc_value     = stack_top_entry_i;
      next_ctrl.acc_write = is_lit;
      next_ctrl.acc_data  = is_lit ? held[`SED_LIT_MSB:0] : `SED_ACC_RESET;
    end
    if (last_phase)
    begin
      case (cyc)
        SED_EXEC:
        begin
          if (is_lit || is_plain)
          begin
            next_cyc = SED_IDLE;
          end
        end
        SED_IDLE:
        begin
          next_cyc  = SED_EXEC;
          next_held = 14'h0000;
        end
        default:
        begin
          next_cyc = SED_EXEC;
        end
      endcase
    end
    next_ctrl.flush = (next_cyc == SED_IDLE);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      phase      <= 2'h0;
      cyc        <= SED_EXEC;
      held       <= 14'h0000;
      ctrl       <= '0;
      pc_value_o <= 13'h0000;
    end
    else
    begin
      phase      <= next_phase;
      cyc        <= next_cyc;
      held       <= next_held;
      ctrl       <= next_ctrl;
      pc_value_o <= next_pc_value;
    end
  end

  assign stack_pop_o   = ctrl.pop;
  assign pc_load_o     = ctrl.pc_load;
  assign acc_write_o   = ctrl.acc_write;
  assign acc_data_o    = ctrl.acc_data;
  assign fetch_flush_o = ctrl.flush;
  // Busy reuses the flush flop, so it leaves the block straight from a register.
  assign busy_o        = ctrl.flush;
  assign phase_o       = phase;

  property p_lit_write;
    @(posedge sys_clk_i) disable iff (reset_i)
      acc_write_o |-> (phase == 2'h3) && is_lit && (acc_data_o == $past(held[7:0]));
  endproperty
  a_lit_write: assert property (p_lit_write) else $error("Accumulator write misplaced.");

  property p_pop_load;
    @(posedge sys_clk_i) disable iff (reset_i)
      stack_pop_o |-> pc_load_o && phase == 2'h3 && cyc == SED_EXEC;
  endproperty
  a_pop_load: assert property (p_pop_load) else $error("Pop without counter load.");

  property p_lit_idle;
    @(posedge sys_clk_i) disable iff (reset_i)
      (acc_write_o && stack_pop_o) |=> (busy_o && !stack_pop_o && !acc_write_o) [*4]
        ##1 !busy_o;
  endproperty
  a_lit_idle: assert property (p_lit_idle) else $error("Literal exit not two cycles.");

  property p_plain_pop;
    @(posedge sys_clk_i) disable iff (reset_i)
      (stack_pop_o && is_plain) |-> !acc_write_o && pc_value_o == $past(stack_top_entry_i);
  endproperty
  a_plain_pop: assert property (p_plain_pop) else $error("Plain exit wrote accumulator.");

  property p_plain_idle;
    @(posedge sys_clk_i) disable iff (reset_i)
      (stack_pop_o && !acc_write_o) |=> busy_o [*4] ##1 !busy_o;
  endproperty
  a_plain_idle: assert property (p_plain_idle) else $error("Plain exit not two cycles.");

  property p_flush;
    @(posedge sys_clk_i) disable iff (reset_i)
      stack_pop_o |=> fetch_flush_o [*4] ##1 !fetch_flush_o;
  endproperty
  a_flush: assert property (p_flush) else $error("Prefetch kept during idle.");

  property p_phase_step;
    @(posedge sys_clk_i) disable iff (reset_i)
      !$past(reset_i) |-> phase_o == $past(phase_o) + 2'h1;
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("Phase counter skipped.");

  property p_idle_quiet;
    @(posedge sys_clk_i) disable iff (reset_i)
      busy_o |-> !stack_pop_o && !pc_load_o && !acc_write_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("Activity in idle cycle.");

  property p_write_pop;
    @(posedge sys_clk_i) disable iff (reset_i)
      acc_write_o |-> stack_pop_o && pc_load_o;
  endproperty
  a_write_pop: assert property (p_write_pop) else $error("Write without pop.");

  property p_pc_hold;
    @(posedge sys_clk_i) disable iff (reset_i)
      !pc_load_o |-> $stable(pc_value_o);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("Return address moved.");

  property p_pop_decode;
    @(posedge sys_clk_i) disable iff (reset_i)
      stack_pop_o |-> is_lit || is_plain;
  endproperty
  a_pop_decode: assert property (p_pop_decode) else $error("Pop on other opcode.");

  property p_idle_hold;
    @(posedge sys_clk_i) disable iff (reset_i)
      (busy_o && phase_o == 2'h0) |=> $stable(held);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("Word taken in idle cycle.");

  property p_acc_zero;
    @(posedge sys_clk_i) disable iff (reset_i)
      !acc_write_o |-> acc_data_o == 8'h00;
  endproperty
  a_acc_zero: assert property (p_acc_zero) else $error("Literal without write.");

  property p_pop_pulse;
    @(posedge sys_clk_i) disable iff (reset_i)
      stack_pop_o |=> !stack_pop_o;
  endproperty
  a_pop_pulse: assert property (p_pop_pulse) else $error("Pop held too long.");
endmodule : sed_exit_decode

// ### sed_pkg.sv
// Types shared by the subroutine exit decoder.
package sed_pkg;
  typedef enum logic [1:0] {SED_EXEC, SED_IDLE} sed_cyc_e;
  typedef struct packed {
    logic       valid;
    logic [13:0] word;
  } sed_instr_s;
  typedef struct packed {
    logic       pop;
    logic       pc_load;
    logic       acc_write;
    logic [7:0] acc_data;
    logic       flush;
  } sed_ctrl_s;
endpackage : sed_pkg

// ### tb.sv
// Self-checking bench for the subroutine exit decoder.
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, rst = 1'b1, vld = 1'b0;
  logic        pop, ld, aw, fl, bz;
  logic [13:0] wrd = 14'h0;
  logic [12:0] top = 13'h0, pc;
  logic [7:0]  ad;
  logic [1:0]  ph;
  logic [31:0] seed = 32'hD371;
  logic [13:0] words[7] = '{14'h8, 14'h3400, 14'h37FF, 14'h9, 14'h3800, 14'h33FF, 14'h8};
  int          miscompares = 0, check_count = 0, exp_pc = 0;
  int          pcq[$];
  always #5 clk = ~clk;
  sed_exit_decode i_dut (.sys_clk_i(clk), .reset_i(rst), .instr_valid_i(vld),
    .instr_word_i(wrd), .stack_top_entry_i(top), .stack_pop_o(pop), .pc_load_o(ld),
    .pc_value_o(pc), .acc_write_o(aw), .acc_data_o(ad), .fetch_flush_o(fl),
    .busy_o(bz), .phase_o(ph));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // Exits get an idle cycle whose fetched word must be ignored.
  task automatic run_slot(input logic v, input logic [13:0] w);
    logic lit, ex;
    lit = w[13:10] == 4'hD;
    ex = v && (lit || w == 14'h8);
    seed = lfsr(seed);
    vld = v;
    wrd = w;
    top = seed[12:0];
    if (ex)
      pcq.push_back(seed[12:0]);
    for (int k = 1; k <= (ex ? 8 : 4); k++)
    begin
      @(negedge clk);
      if (k == 3 && ex)
        exp_pc = pcq.pop_front();
      check(ph, k % 4);
      check({pop, ld}, {2{ex && k == 3}});
      check({aw, ad}, (lit && ex && k == 3) ? {1'b1, w[7:0]} : 9'h0);
      check({bz, fl}, {2{ex && k >= 4 && k <= 7}});
      check(pc, exp_pc);
      if (ex && k == 4)
        wrd = {4'hD, seed[21:12]};
    end
  endtask : run_slot
  initial
  begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8 && ph !== 2'h0; i++)
      @(negedge clk);
    if (ph === 2'h0)
    begin
      foreach (words[i])
        run_slot(1'b1, words[i]);
      run_slot(1'b0, 14'h3455);
      $display("test boundary words done");
      for (int i = 0; i < 40; i++)
      begin
        seed = lfsr(seed);
        case (seed[1:0])
          2'h0: run_slot(1'b1, 14'h8);
          2'h1: run_slot(1'b1, {4'hD, seed[13:4]});
          2'h2: run_slot(1'b1, seed[17:4]);
          default: run_slot(1'b0, 14'h8);
        endcase
      end
      $display("test random words done");
    end
    else
      miscompares++;
    stop_test();
  end
endmodule : tb
